//--- rtl/exec_consts.vh
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH

// opcode fields, upper bits of the 14-bit instruction word
`define OPC_LIT_HI      13:9
`define OPC_ADD_IMM     5'h1F
`define OPC_AND_IMM_HI  13:8
`define OPC_AND_IMM     6'h39
`define OPC_REG_HI      13:8
`define OPC_ADD_REG     6'h07
`define OPC_AND_REG     6'h05
`define OPC_BIT_HI      13:10
`define OPC_BIT_CLR     4'h4
`define OPC_BIT_SET     4'h5
`define OPC_BIT_TST0    4'h6

// operand fields
`define FLD_LIT         7:0
`define FLD_ADDR        6:0
`define FLD_DEST        7
`define FLD_BIT         9:7

// alu operations
`define ALU_ADD         2'h0
`define ALU_AND         2'h1
`define ALU_BCLR        2'h2
`define ALU_BSET        2'h3

// special file addresses
`define ADDR_TIMER_ZERO 7'h01
`define ADDR_PORT       7'h05

// reset values
`define W_RESET         8'h00
`define LATCH_RESET     8'h00

`endif

//--- rtl/alu_unit.v
`timescale 1ns/1ps
`include "exec_consts.vh"

module alu_unit (
  input  wire [1:0] op,
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire [2:0] bit_sel,
  output reg  [7:0] result,
  output reg        carry,
  output reg        dcarry,
  output wire       zero
);

  reg [8:0] sum9;
  reg [4:0] sum5;
  reg [7:0] mask;

  always @* begin
    sum9   = {1'b0, a} + {1'b0, b};
    sum5   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    mask   = 8'h01 << bit_sel;
    carry  = sum9[8];
    dcarry = sum5[4];
    case (op)
      `ALU_ADD:  result = sum9[7:0];
      `ALU_AND:  result = a & b;
      `ALU_BCLR: result = b & ~mask;
      `ALU_BSET: result = b | mask;
      default:   result = sum9[7:0];
    endcase
  end

  assign zero = (result == 8'h00);

endmodule

//--- rtl/add_and_bit_ops_execute.v
`timescale 1ns/1ps
`include "exec_consts.vh"

// What this block does
// - read-modify-write of the port register uses sensed pin levels, not latch
// - writing the timer-zero count clears the prescaler when assigned to it
// - a true conditional test takes two cycles, the second a nop
// - add immediate: accumulator plus 8-bit literal into accumulator, three flags
// - add register: accumulator plus register, destination by select, three flags
// - and immediate: accumulator and literal into accumulator, zero flag only
// - and register: accumulator and register, destination by select, zero flag only
// - bit clear forces one register bit low, flags untouched
// - bit set forces one register bit high, flags untouched
// - test-skip-if-zero discards next instruction when bit is zero
module add_and_bit_ops_execute #(
  parameter DEPTH = 128
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        instr_valid,
  input  wire [13:0] instr,
  output wire        instr_ready,
  input  wire [7:0]  port_pins,
  output reg  [7:0]  port_latch_q,
  input  wire [7:0]  timer_zero_count,
  input  wire        prescaler_on_timer,
  output reg         timer_wr_q,
  output reg  [7:0]  timer_wdata_q,
  output reg         prescaler_clr_q,
  output reg  [7:0]  w_q,
  output reg         carry_q,
  output reg         nibble_overflow_flag,
  output reg         zero_q,
  output reg         skip_next_q,
  output reg         nop_cycle_q,
  output reg         unknown_op_q
);

  reg        rst_meta_q;
  reg        rst_sync_q;
  reg  [7:0] pin_meta_q;
  reg  [7:0] pin_sync_q;
  reg  [7:0] file_mem [0:DEPTH-1];

  wire       take;
  wire [6:0] addr;
  wire       dest_file;
  wire [2:0] bit_sel;
  wire [7:0] literal;
  wire       add_immediate_op;
  wire       and_immediate_op;
  wire       add_register_op;
  wire       and_register_op;
  wire       bit_clear_op;
  wire       bit_set_op;
  wire       test_skip_if_zero_op;
  wire       is_imm;
  wire       is_known;

  reg  [7:0] file_rd;
  reg  [1:0] alu_op;
  reg  [7:0] alu_a;
  reg  [7:0] alu_b;
  wire [7:0] alu_res;
  wire       alu_c;
  wire       alu_dc;
  wire       alu_z;

  reg        wr_w;
  reg        wr_file;
  reg        upd_cdc;
  reg        upd_z;

  // reset release is synchronised; assertion stays asynchronous
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // pins come from outside the clock domain
  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= port_pins;
      pin_sync_q <= pin_meta_q;
    end
  end

  // no instruction is taken during the nop cycle of a skip
  assign instr_ready = rst_sync_q & ~nop_cycle_q;
  assign take        = instr_valid & instr_ready;

  assign addr      = instr[`FLD_ADDR];
  assign dest_file = instr[`FLD_DEST];
  assign bit_sel   = instr[`FLD_BIT];
  assign literal   = instr[`FLD_LIT];

  assign add_immediate_op     = (instr[`OPC_LIT_HI] == `OPC_ADD_IMM);
  assign and_immediate_op     = (instr[`OPC_AND_IMM_HI] == `OPC_AND_IMM);
  assign add_register_op      = (instr[`OPC_REG_HI] == `OPC_ADD_REG);
  assign and_register_op      = (instr[`OPC_REG_HI] == `OPC_AND_REG);
  assign bit_clear_op         = (instr[`OPC_BIT_HI] == `OPC_BIT_CLR);
  assign bit_set_op           = (instr[`OPC_BIT_HI] == `OPC_BIT_SET);
  assign test_skip_if_zero_op = (instr[`OPC_BIT_HI] == `OPC_BIT_TST0);
  assign is_imm               = add_immediate_op | and_immediate_op;
  assign is_known = is_imm | add_register_op | and_register_op | bit_clear_op |
                    bit_set_op | test_skip_if_zero_op;

  // the port address reads the pins so a read-modify-write cannot
  // copy a stale latch value back over an externally driven pin
  always @* begin
    if (addr == `ADDR_PORT)
      file_rd = pin_sync_q;
    else if (addr == `ADDR_TIMER_ZERO)
      file_rd = timer_zero_count;
    else
      file_rd = file_mem[addr];
  end

  always @* begin
    alu_op  = `ALU_ADD;
    alu_a   = w_q;
    alu_b   = file_rd;
    wr_w    = 1'b0;
    wr_file = 1'b0;
    upd_cdc = 1'b0;
    upd_z   = 1'b0;
    if (add_immediate_op) begin
      alu_b   = literal;
      wr_w    = 1'b1;
      upd_cdc = 1'b1;
      upd_z   = 1'b1;
    end else if (and_immediate_op) begin
      alu_op  = `ALU_AND;
      alu_b   = literal;
      wr_w    = 1'b1;
      upd_z   = 1'b1;
    end else if (add_register_op) begin
      wr_w    = ~dest_file;
      wr_file = dest_file;
      upd_cdc = 1'b1;
      upd_z   = 1'b1;
    end else if (and_register_op) begin
      alu_op  = `ALU_AND;
      wr_w    = ~dest_file;
      wr_file = dest_file;
      upd_z   = 1'b1;
    end else if (bit_clear_op) begin
      alu_op  = `ALU_BCLR;
      wr_file = 1'b1;
    end else if (bit_set_op) begin
      alu_op  = `ALU_BSET;
      wr_file = 1'b1;
    end
  end

  alu_unit u_alu (
    .op      (alu_op),
    .a       (alu_a),
    .b       (alu_b),
    .bit_sel (bit_sel),
    .result  (alu_res),
    .carry   (alu_c),
    .dcarry  (alu_dc),
    .zero    (alu_z)
  );

  // general file storage; the port and timer addresses live elsewhere
  always @(posedge clk) begin
    if (take && wr_file && addr != `ADDR_PORT && addr != `ADDR_TIMER_ZERO)
      file_mem[addr] <= alu_res;
  end

  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      w_q                  <= `W_RESET;
      carry_q              <= 1'b0;
      nibble_overflow_flag <= 1'b0;
      zero_q               <= 1'b0;
      port_latch_q         <= `LATCH_RESET;
      timer_wr_q           <= 1'b0;
      timer_wdata_q        <= 8'h00;
      prescaler_clr_q      <= 1'b0;
      skip_next_q          <= 1'b0;
      nop_cycle_q          <= 1'b0;
      unknown_op_q         <= 1'b0;
    end else begin
      timer_wr_q      <= 1'b0;
      prescaler_clr_q <= 1'b0;
      skip_next_q     <= 1'b0;
      nop_cycle_q     <= 1'b0;
      unknown_op_q    <= 1'b0;
      if (take) begin
        unknown_op_q <= ~is_known;
        if (wr_w)
          w_q <= alu_res;
        if (upd_cdc) begin
          carry_q              <= alu_c;
          nibble_overflow_flag <= alu_dc;
        end
        if (upd_z)
          zero_q <= alu_z;
        if (wr_file && addr == `ADDR_PORT)
          port_latch_q <= alu_res;
        if (wr_file && addr == `ADDR_TIMER_ZERO) begin
          timer_wr_q      <= 1'b1;
          timer_wdata_q   <= alu_res;
          prescaler_clr_q <= prescaler_on_timer;
        end
        // bit zero: the fetched follower is dropped and a nop takes its slot
        if (test_skip_if_zero_op && !file_rd[bit_sel]) begin
          skip_next_q <= 1'b1;
          nop_cycle_q <= 1'b1;
        end
      end
    end
  end

endmodule

//--- testbench/add_and_bit_ops_execute_monitor.sv
`timescale 1ns/1ps
module exec_monitor (
  input wire        clk,
  input wire        rst_b,
  input wire        instr_valid,
  input wire [13:0] instr,
  input wire        instr_ready,
  input wire [7:0]  timer_zero_count,
  input wire        prescaler_on_timer,
  input wire        timer_wr_q,
  input wire [7:0]  timer_wdata_q,
  input wire        prescaler_clr_q,
  input wire [7:0]  w_q,
  input wire        carry_q,
  input wire        nibble_overflow_flag,
  input wire        zero_q,
  input wire        skip_next_q,
  input wire        nop_cycle_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire tk = instr_valid && instr_ready;
  sequence add_imm_s;
    tk && instr[13:9] == 5'h1F;
  endsequence
  sequence gap_s;
    !instr_ready ##1 instr_ready;
  endsequence
  sum_carry_a: assert property (add_imm_s |=>
    {carry_q, w_q} == $past(w_q) + $past(instr[7:0])) else $error("bad sum");
  nibble_carry_a: assert property (add_imm_s |=>
    nibble_overflow_flag == (($past(w_q[3:0]) + $past(instr[3:0]) + 5'h00) >> 4))
    else $error("bad nibble carry");
  add_zero_a: assert property (add_imm_s |=> zero_q == (w_q == 8'h00))
    else $error("bad zero");
  and_imm_a: assert property (tk && instr[13:8] == 6'h39 |=>
    w_q == ($past(w_q) & $past(instr[7:0])) && $stable(carry_q)) else $error("bad and");
  bit_flags_a: assert property (tk && instr[13:12] == 2'h1 && instr[11:10] != 2'h3 |=>
    $stable({carry_q, nibble_overflow_flag, zero_q, w_q})) else $error("bit op moved flags");
  skip_gap_a: assert property (nop_cycle_q |-> skip_next_q ##0 gap_s)
    else $error("bad nop cycle");
  presc_pair_a: assert property (timer_wr_q || prescaler_clr_q |->
    timer_wr_q && prescaler_clr_q == $past(prescaler_on_timer)) else $error("bad clear");
  timer_write_a: assert property (tk && instr == 14'h0781 |=> timer_wr_q &&
    timer_wdata_q == 8'($past(w_q) + $past(timer_zero_count))) else $error("bad timer write");
endmodule
bind add_and_bit_ops_execute exec_monitor mon (
  .clk                  (clk),
  .rst_b                (rst_b),
  .instr_valid          (instr_valid),
  .instr                (instr),
  .instr_ready          (instr_ready),
  .timer_zero_count     (timer_zero_count),
  .prescaler_on_timer   (prescaler_on_timer),
  .timer_wr_q           (timer_wr_q),
  .timer_wdata_q        (timer_wdata_q),
  .prescaler_clr_q      (prescaler_clr_q),
  .w_q                  (w_q),
  .carry_q              (carry_q),
  .nibble_overflow_flag (nibble_overflow_flag),
  .zero_q               (zero_q),
  .skip_next_q          (skip_next_q),
  .nop_cycle_q          (nop_cycle_q)
);

//--- testbench/add_and_bit_ops_execute_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module add_and_bit_ops_execute_tb_top;
  reg        clk = 1'b0;
  reg        rst_b = 1'b0;
  reg        instr_valid = 1'b0;
  reg [13:0] instr = 14'h0000;
  reg [7:0]  port_pins = 8'h00;
  reg [7:0]  timer_zero_count = 8'h10;
  reg        prescaler_on_timer = 1'b0;
  wire       instr_ready, timer_wr_q, prescaler_clr_q, carry_q;
  wire       nibble_overflow_flag, zero_q, skip_next_q, nop_cycle_q, unknown_op_q;
  wire [7:0] port_latch_q, timer_wdata_q, w_q;
  integer    err_total = 0;
  integer    check_count = 0;
  integer    b;
  always #10 clk = ~clk;
  add_and_bit_ops_execute uut (
    .clk                  (clk),
    .rst_b                (rst_b),
    .instr_valid          (instr_valid),
    .instr                (instr),
    .instr_ready          (instr_ready),
    .port_pins            (port_pins),
    .port_latch_q         (port_latch_q),
    .timer_zero_count     (timer_zero_count),
    .prescaler_on_timer   (prescaler_on_timer),
    .timer_wr_q           (timer_wr_q),
    .timer_wdata_q        (timer_wdata_q),
    .prescaler_clr_q      (prescaler_clr_q),
    .w_q                  (w_q),
    .carry_q              (carry_q),
    .nibble_overflow_flag (nibble_overflow_flag),
    .zero_q               (zero_q),
    .skip_next_q          (skip_next_q),
    .nop_cycle_q          (nop_cycle_q),
    .unknown_op_q         (unknown_op_q)
  );
  // ends at the falling edge after the word is taken, where results have settled
  task ex(input [13:0] w); begin
    @(posedge clk);
    instr <= w;
    instr_valid <= 1'b1;
    @(negedge clk);
    while (instr_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
  end endtask
  task ldw(input [7:0] k); begin
    ex(14'h3900);
    ex({6'h3E, k});
  end endtask
  // file memory is not reset: and with w=0 clears it first
  task setf(input [6:0] f, input [7:0] k); begin
    ldw(8'h00);
    ex({7'h0B, f});
    ldw(k);
    ex({7'h0F, f});
  end endtask
  task rd(input [6:0] f); begin
    ldw(8'hFF);
    ex({7'h0A, f});
  end endtask
  task flags(input [7:0] w, input [2:0] f); begin
    `CHK("w", w, w_q)
    `CHK("flags", f, {carry_q, nibble_overflow_flag, zero_q})
  end endtask
  task t_add; begin
    ldw(8'hFB);
    flags(8'hFB, 3'h0);
    ex(14'h3E05);
    flags(8'h00, 3'h7);
    ldw(8'h08);
    ex(14'h3E08);
    flags(8'h10, 3'h2);
  end endtask
  task t_reg; begin
    setf(7'h20, 8'h81);
    ex({7'h0E, 7'h20});
    flags(8'h02, 3'h4);
    ex({7'h0F, 7'h20});
    flags(8'h02, 3'h0);
    rd(7'h20);
    `CHK("f", 8'h83, w_q)
    ex(14'h3903);
    ex({7'h0B, 7'h20});
    rd(7'h20);
    `CHK("f", 8'h03, w_q)
    ex(14'h3900);
    `CHK("z", 1'b1, zero_q)
  end endtask
  task t_bits; begin
    setf(7'h21, 8'hFF);
    for (b = 0; b < 8; b = b + 1) begin
      ex({4'h4, b[2:0], 7'h21});
      rd(7'h21);
      `CHK("clr", ~(8'h01 << b), w_q)
      ex({4'h5, b[2:0], 7'h21});
      rd(7'h21);
      `CHK("set", 8'hFF, w_q)
    end
  end endtask
  task t_skip; begin
    setf(7'h22, 8'h01);
    ex({4'h6, 3'h0, 7'h22});
    `CHK("skip", 3'h0, {skip_next_q, nop_cycle_q, unknown_op_q})
    ex({4'h6, 3'h1, 7'h22});
    `CHK("skip", 3'h6, {skip_next_q, nop_cycle_q, instr_ready})
    @(negedge clk);
    `CHK("gap", 2'h1, {nop_cycle_q, instr_ready})
    // an unsupported word is a single-cycle nop: flagged, no gap, accumulator kept
    ex(14'h0000);
    `CHK("unk", {2'h2, 8'h01}, {unknown_op_q, nop_cycle_q, w_q})
  end endtask
  task t_timer; begin
    ldw(8'h22);
    @(posedge clk);
    prescaler_on_timer <= 1'b1;
    ex(14'h0781);
    `CHK("tmr", {2'h3, 8'h32}, {timer_wr_q, prescaler_clr_q, timer_wdata_q})
    @(posedge clk);
    prescaler_on_timer <= 1'b0;
    ex(14'h0781);
    `CHK("tmr", {2'h2, 8'h32}, {timer_wr_q, prescaler_clr_q, timer_wdata_q})
    ex(14'h0701);
    `CHK("tmr", {1'b0, 8'h32}, {timer_wr_q, w_q})
  end endtask
  // pins settle through the two sync flops before each access
  task t_port; begin
    @(posedge clk);
    port_pins <= 8'hA0;
    repeat (3) @(posedge clk);
    ex(14'h1405);
    `CHK("latch", 8'hA1, port_latch_q)
    @(posedge clk);
    port_pins <= 8'h00;
    repeat (3) @(posedge clk);
    ex({4'h4, 3'h7, 7'h05});
    `CHK("latch", 8'h00, port_latch_q)
  end endtask
  task results; begin
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_add;
    t_reg;
    t_bits;
    t_skip;
    t_timer;
    t_port;
    results;
  end
  initial begin
    #100000;
    err_total++;
    results;
  end
endmodule
